// File: include/mst_microstep_regs.svh
// register offsets, field ranges, reset values and timing counts
// assumes inclusion by name from the design files
`ifndef MST_MICROSTEP_REGS_SVH
`define MST_MICROSTEP_REGS_SVH

// register offsets on the 6-bit serial address
`define MST_ADDR_SYNC_PWM 6'h20
`define MST_ADDR_ALPHA_EXC 6'h22
`define MST_ADDR_AB_PEAK 6'h23
`define MST_ADDR_BETA_EXC 6'h27
`define MST_ADDR_CD_PEAK 6'h28
`define MST_ADDR_STATUS 6'h2F

// reset values
`define MST_RST_SYNC_PWM 16'h3C0A
`define MST_RST_EXCITE 16'h0003
`define MST_RST_PEAK 16'h0000

// field ranges inside the 16-bit words
`define MST_WAIT_FIELD 7:0
`define MST_DIV_FIELD 12:8
`define MST_RES_FIELD 14:13
`define MST_TRIM_FIELD 13:8
`define MST_PEAK_LO_FIELD 7:0
`define MST_PEAK_HI_FIELD 15:8

// timing: one wait unit is 8192 oscillator cycles, 303.4 us at 27 MHz
`define MST_WAIT_UNIT_CYC 8192
`define MST_CHOP_BASE 8
`define MST_QUAD_PHASE 9'h080

// serial frame: 8 address bits then 16 data bits, lsb first
`define MST_ADDR_BITS 5'h08
`define MST_FRAME_BITS 5'h18

`endif

// File: include/mst_pkg.sv
// types shared by the timing and setup logic
// assumes the register header sits on the include path
package mst_pkg;
   // sequence phase of one frame, one-hot
   typedef enum logic [2:0]
   {
      MST_IDLE = 3'b001,
      MST_START = 3'b010,
      MST_EXCITE = 3'b100
   } mst_phase_t;

   // one serial register word
   typedef logic [15:0] mst_word_t;
endpackage

// File: hdl/mst_wait_timer.sv
// wait timer counting a field value times a fixed unit of clock cycles
// assumes start and abort come from logic on the same clock
`timescale 1ns/10ps
`include "mst_microstep_regs.svh"

module mst_wait_timer #(
   parameter int UNIT_CYC = `MST_WAIT_UNIT_CYC
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic start_i,
   input wire logic abort_i,
   input wire logic [7:0] field_i,
   output logic busy_o,
   output logic done_o
);
   localparam int CW = $clog2(255 * UNIT_CYC + 1);

   // refuse a unit the counter cannot hold
   if (UNIT_CYC < 1)
   begin : g_bad_unit
      $error("wait unit must be at least one cycle");
   end

   logic [CW-1:0] cnt; // remaining cycles minus one

   // load on start, count down, pulse done at the end
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         cnt <= '0;
         busy_o <= 1'b0;
         done_o <= 1'b0;
      end
      else
      begin
         done_o <= 1'b0;
         if (abort_i)
         begin
            // abort wins, so a new frame never overlaps an excitation wait
            busy_o <= 1'b0;
         end
         else if (start_i)
         begin
            // a zero field never starts, so no done and no update
            busy_o <= (field_i != 8'h00);
            cnt <= CW'(int'(field_i) * UNIT_CYC - 1);
         end
         else if (busy_o)
         begin
            if (cnt == '0)
            begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
            else
            begin
               cnt <= cnt - 1'b1;
            end
         end
      end
   end
endmodule

// File: hdl/mst_coil_chopper.sv
// pwm chopper for one coil driver at its peak duty
// assumes its settings change only at frame-aligned update points
`timescale 1ns/10ps
`include "mst_microstep_regs.svh"

module mst_coil_chopper (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic enable_i,
   input wire logic [4:0] div_i,
   input wire logic [1:0] res_i,
   input wire logic [7:0] width_i,
   output logic pwm_o
);
   logic [4:0] eff_div; // divider with zero treated as one
   logic [10:0] period; // pwm period in clock cycles
   logic [10:0] on_cnt; // high time in clock cycles
   logic [10:0] cnt; // position inside the period

   // period and high time; zero divider acts as one
   always_comb
   begin
      eff_div = (div_i == 5'h00) ? 5'h01 : div_i;
      period = 11'(eff_div * `MST_CHOP_BASE) << res_i;
      on_cnt = 11'(width_i) << res_i;
   end

   // free running period counter; wraps early if the period shrinks
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         cnt <= 11'h000;
      else if (cnt >= period - 11'h001)
         cnt <= 11'h000;
      else
         cnt <= cnt + 11'h001;
   end

   // duty above 100 percent saturates at full on
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         pwm_o <= 1'b0;
      else
         pwm_o <= enable_i && (width_i != 8'h00) &&
            ((on_cnt >= period) || (cnt < on_cnt));
   end

   a_zero_width_off: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (width_i == 8'h00) |=> !pwm_o)
      else $error("zero peak width left the coil driven");

   a_over_full_on: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (enable_i && width_i != 8'h00 && on_cnt >= period) |=> pwm_o)
      else $error("duty above full scale was not held on");

   a_div_zero_one: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (div_i == 5'h00) |-> (period == (11'h008 << res_i)))
      else $error("zero divider did not act as one");
endmodule

// File: hdl/mst_microstep_timing_setup.sv
// frame-synchronised setup and timing logic of a two-motor driver
// assumes serial pins and frame sync arrive asynchronously to clock_i
//
// Summary of operation
// - written data applies only after start wait
// - start wait counts from frame sync rise
// - excitation allowed once start wait falls
// - zero start wait blocks any update
// - start wait is field times 8192 cycles
// - each motor rotates after its excitation wait
// - excitation waits start at start wait end
// - zero excitation wait blocks that motor update
// - excitation wait is field times 8192 cycles
// - divider one to thirty-one sets pwm period
// - divider zero behaves like divider one
// - pwm period is divider, eight, resolution power
// - phase trim offsets coil difference from ninety
// - trim step is 360/512 degree, signed
// - peak width over divider times eight gives duty
// - zero peak width turns coil current off
// - two peak widths share each peak register
// - settings reapplied every frame once written
`timescale 1ns/10ps
`include "mst_microstep_regs.svh"

module mst_microstep_timing_setup #(
   parameter int UNIT_CYC = `MST_WAIT_UNIT_CYC
) (
   input wire logic clock_i,
   input wire logic rst_n_i,
   input wire logic serial_cs_i,
   input wire logic serial_clk_i,
   input wire logic serial_din_i,
   output logic serial_dout_o,
   output logic serial_dout_oe_o,
   input wire logic frame_sync_in_i,
   output logic [3:0] coil_pwm_o,
   output logic [8:0] alpha_phase_diff_o,
   output logic [8:0] beta_phase_diff_o,
   output logic frame_start_wait_o,
   output logic alpha_excite_wait_o,
   output logic beta_excite_wait_o,
   output logic alpha_run_o,
   output logic beta_run_o
);
   localparam int LW = $clog2(255 * UNIT_CYC + 1) + 1;

   // refuse a wait unit the timers cannot serve
   if (UNIT_CYC < 1)
   begin : g_bad_unit
      $error("wait unit must be at least one cycle");
   end

   // pin synchronisers: cs, clk, din, frame sync
   logic [3:0] sync_a; // first stage, read by sync_b only
   logic [3:0] sync_b; // second stage, safe to use
   logic [3:0] sync_c; // delayed copy for edge detection
   logic cs_on; // serial select active
   logic sclk_rise; // serial clock rising edge
   logic sclk_fall; // serial clock falling edge
   logic cs_fall; // end of a serial frame
   logic fs_rise; // frame sync rising edge

   // serial slave state
   logic [4:0] bit_cnt; // bits received in this frame
   logic [23:0] shift_in; // received bits, lsb first
   logic is_read; // frame is a read access
   logic [15:0] out_shift; // read data going out
   logic wr_stb; // one-cycle register write
   logic [5:0] wr_addr; // address of the write
   logic [15:0] wr_data; // data of the write

   // shadow registers written by the host
   mst_pkg::mst_word_t sync_pwm_reg;
   mst_pkg::mst_word_t alpha_exc_reg;
   mst_pkg::mst_word_t ab_peak_reg;
   mst_pkg::mst_word_t beta_exc_reg;
   mst_pkg::mst_word_t cd_peak_reg;

   // settings in effect on the outputs
   logic [4:0] act_div;
   logic [1:0] act_res;
   logic [5:0] act_alpha_trim;
   logic [5:0] act_beta_trim;
   logic [7:0] act_peak [4];

   // sequencing
   mst_pkg::mst_phase_t phase;
   mst_pkg::mst_phase_t next_phase;
   logic start_busy;
   logic start_done;
   logic alpha_busy;
   logic alpha_done;
   logic beta_busy;
   logic beta_done;

   // assertion helpers
   logic [LW-1:0] busy_len; // cycles the start wait has run
   logic [LW-1:0] want_len; // cycles it should run

   // sign-extend a trim code onto the ninety degree base
   function automatic logic [8:0] phase_diff(input logic [5:0] trim);
      phase_diff = `MST_QUAD_PHASE + {{3{trim[5]}}, trim};
   endfunction

   // two flops before use; third stage only for edges
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync_a <= 4'h0;
         sync_b <= 4'h0;
         sync_c <= 4'h0;
      end
      else
      begin
         sync_a <= {frame_sync_in_i, serial_din_i, serial_clk_i, serial_cs_i};
         sync_b <= sync_a;
         sync_c <= sync_b;
      end
   end

   assign cs_on = sync_b[0];
   assign cs_fall = sync_c[0] & ~sync_b[0];
   assign sclk_rise = sync_b[1] & ~sync_c[1];
   assign sclk_fall = ~sync_b[1] & sync_c[1];
   assign fs_rise = sync_b[3] & ~sync_c[3];

   // shift in address then data while select is high
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         bit_cnt <= 5'h00;
         shift_in <= 24'h000000;
      end
      else if (!cs_on)
         bit_cnt <= 5'h00;
      else if (sclk_rise && bit_cnt < `MST_FRAME_BITS)
      begin
         shift_in <= {sync_b[2], shift_in[23:1]};
         bit_cnt <= bit_cnt + 5'h01;
      end
   end

   // read side: load data after the address byte, shift on falling edge
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         is_read <= 1'b0;
         out_shift <= 16'h0000;
         serial_dout_oe_o <= 1'b0;
      end
      else if (!cs_on)
      begin
         is_read <= 1'b0;
         serial_dout_oe_o <= 1'b0;
      end
      else if (bit_cnt == `MST_ADDR_BITS && !is_read && !serial_dout_oe_o)
      begin
         // address byte sits in the top of the shifter here
         is_read <= shift_in[22];
         serial_dout_oe_o <= shift_in[22];
         unique case (shift_in[21:16])
            `MST_ADDR_SYNC_PWM: out_shift <= sync_pwm_reg;
            `MST_ADDR_ALPHA_EXC: out_shift <= alpha_exc_reg;
            `MST_ADDR_AB_PEAK: out_shift <= ab_peak_reg;
            `MST_ADDR_BETA_EXC: out_shift <= beta_exc_reg;
            `MST_ADDR_CD_PEAK: out_shift <= cd_peak_reg;
            `MST_ADDR_STATUS: out_shift <= {10'h000, phase, alpha_busy,
                                            beta_busy, start_busy};
            default: out_shift <= 16'h0000; // unmapped reads as zero
         endcase
      end
      else if (is_read && sclk_fall)
         out_shift <= {1'b0, out_shift[15:1]};
   end

   assign serial_dout_o = out_shift[0];

   // full write frames commit when select drops; short frames are dropped
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         wr_stb <= 1'b0;
         wr_addr <= 6'h00;
         wr_data <= 16'h0000;
      end
      else
      begin
         wr_stb <= cs_fall && bit_cnt == `MST_FRAME_BITS && !shift_in[6];
         wr_addr <= shift_in[5:0];
         wr_data <= shift_in[23:8];
      end
   end

   // shadow registers keep their value until rewritten
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         sync_pwm_reg <= `MST_RST_SYNC_PWM;
         alpha_exc_reg <= `MST_RST_EXCITE;
         ab_peak_reg <= `MST_RST_PEAK;
         beta_exc_reg <= `MST_RST_EXCITE;
         cd_peak_reg <= `MST_RST_PEAK;
      end
      else if (wr_stb)
      begin
         // unused bits are kept zero so reads show them as zero
         unique case (wr_addr)
            `MST_ADDR_SYNC_PWM: sync_pwm_reg <= wr_data & 16'h7FFF;
            `MST_ADDR_ALPHA_EXC: alpha_exc_reg <= wr_data & 16'h3FFF;
            `MST_ADDR_AB_PEAK: ab_peak_reg <= wr_data;
            `MST_ADDR_BETA_EXC: beta_exc_reg <= wr_data & 16'h3FFF;
            `MST_ADDR_CD_PEAK: cd_peak_reg <= wr_data;
            default: ;
         endcase
      end
   end

   // start wait from each frame sync rise
   mst_wait_timer #(
      .UNIT_CYC(UNIT_CYC)
   ) u_start_wait (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(fs_rise),
      .abort_i(1'b0),
      .field_i(sync_pwm_reg[`MST_WAIT_FIELD]),
      .busy_o(start_busy),
      .done_o(start_done)
   );

   // excitation waits start on the start wait falling edge
   mst_wait_timer #(
      .UNIT_CYC(UNIT_CYC)
   ) u_alpha_wait (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(start_done),
      .abort_i(fs_rise),
      .field_i(alpha_exc_reg[`MST_WAIT_FIELD]),
      .busy_o(alpha_busy),
      .done_o(alpha_done)
   );

   mst_wait_timer #(
      .UNIT_CYC(UNIT_CYC)
   ) u_beta_wait (
      .clock_i(clock_i),
      .rst_n_i(rst_n_i),
      .start_i(start_done),
      .abort_i(fs_rise),
      .field_i(beta_exc_reg[`MST_WAIT_FIELD]),
      .busy_o(beta_busy),
      .done_o(beta_done)
   );

   // frame phase, shown in the status word
   always_comb
   begin
      next_phase = phase;
      unique case (phase)
         mst_pkg::MST_IDLE:
            if (fs_rise && sync_pwm_reg[`MST_WAIT_FIELD] != 8'h00)
               next_phase = mst_pkg::MST_START;
         mst_pkg::MST_START:
            if (start_done)
               next_phase = mst_pkg::MST_EXCITE;
         mst_pkg::MST_EXCITE:
            if (fs_rise && sync_pwm_reg[`MST_WAIT_FIELD] != 8'h00)
               next_phase = mst_pkg::MST_START;
            else if (!alpha_busy && !beta_busy && !start_done)
               next_phase = mst_pkg::MST_IDLE;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
         phase <= mst_pkg::MST_IDLE;
      else
         phase <= next_phase;
   end

   // chop settings take effect at start wait end, again every frame
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         act_div <= 5'(`MST_RST_SYNC_PWM >> 8);
         act_res <= 2'(`MST_RST_SYNC_PWM >> 13);
      end
      else if (start_done)
      begin
         act_div <= sync_pwm_reg[`MST_DIV_FIELD];
         act_res <= sync_pwm_reg[`MST_RES_FIELD];
      end
   end

   // per-motor data taken at the end of its own excitation wait
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         act_alpha_trim <= 6'h00;
         act_beta_trim <= 6'h00;
         for (int i = 0; i < 4; i++)
            act_peak[i] <= 8'h00;
         alpha_run_o <= 1'b0;
         beta_run_o <= 1'b0;
      end
      else
      begin
         if (alpha_done)
         begin
            act_alpha_trim <= alpha_exc_reg[`MST_TRIM_FIELD];
            act_peak[0] <= ab_peak_reg[`MST_PEAK_LO_FIELD];
            act_peak[1] <= ab_peak_reg[`MST_PEAK_HI_FIELD];
            alpha_run_o <= 1'b1;
         end
         if (beta_done)
         begin
            act_beta_trim <= beta_exc_reg[`MST_TRIM_FIELD];
            act_peak[2] <= cd_peak_reg[`MST_PEAK_LO_FIELD];
            act_peak[3] <= cd_peak_reg[`MST_PEAK_HI_FIELD];
            beta_run_o <= 1'b1;
         end
      end
   end

   // registered indications and coil phase differences
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         frame_start_wait_o <= 1'b0;
         alpha_excite_wait_o <= 1'b0;
         beta_excite_wait_o <= 1'b0;
         alpha_phase_diff_o <= `MST_QUAD_PHASE;
         beta_phase_diff_o <= `MST_QUAD_PHASE;
      end
      else
      begin
         frame_start_wait_o <= start_busy;
         alpha_excite_wait_o <= alpha_busy;
         beta_excite_wait_o <= beta_busy;
         alpha_phase_diff_o <= phase_diff(act_alpha_trim);
         beta_phase_diff_o <= phase_diff(act_beta_trim);
      end
   end

   // one chopper per coil driver, enabled once its motor runs
   for (genvar g = 0; g < 4; g++)
   begin : g_coil
      mst_coil_chopper u_chop (
         .clock_i(clock_i),
         .rst_n_i(rst_n_i),
         .enable_i((g < 2) ? alpha_run_o : beta_run_o),
         .div_i(act_div),
         .res_i(act_res),
         .width_i(act_peak[g]),
         .pwm_o(coil_pwm_o[g])
      );
   end

   // start wait length tracker for checking
   always_ff @(posedge clock_i or negedge rst_n_i)
   begin
      if (!rst_n_i)
      begin
         busy_len <= '0;
         want_len <= '0;
      end
      else
      begin
         busy_len <= fs_rise ? '0 : (start_busy ? busy_len + 1'b1 : '0);
         if (fs_rise)
            want_len <= LW'(int'(sync_pwm_reg[`MST_WAIT_FIELD]) * UNIT_CYC);
      end
   end

   a_update_after_wait: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      ($changed(act_div) || $changed(act_res)) |-> $past(start_done))
      else $error("chop setting changed outside the wait end");

   a_start_on_sync: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (fs_rise && sync_pwm_reg[`MST_WAIT_FIELD] != 8'h00) |=> start_busy)
      else $error("start wait did not begin at frame sync");

   a_excite_gated: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (alpha_busy || beta_busy) |-> !start_busy)
      else $error("excitation wait ran during start wait");

   a_zero_no_update: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (fs_rise && sync_pwm_reg[`MST_WAIT_FIELD] == 8'h00) |=> !start_busy)
      else $error("zero start wait still started");

   a_wait_length: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      start_done |-> (busy_len == want_len))
      else $error("start wait length wrong");

   a_excite_start: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (start_done && !fs_rise && alpha_exc_reg[`MST_WAIT_FIELD] != 8'h00) |=> alpha_busy)
      else $error("alpha excitation wait did not start");

   a_excite_zero: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (start_done && beta_exc_reg[`MST_WAIT_FIELD] == 8'h00) |=> !beta_busy [*2])
      else $error("zero beta excitation wait still started");

   a_run_after_excite: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      $rose(alpha_run_o) |-> $past(alpha_done))
      else $error("alpha ran before its excitation wait ended");

   a_phase_offset: assert property (
      @(posedge clock_i) disable iff (!rst_n_i)
      (act_beta_trim == 6'h20) |=> (beta_phase_diff_o == 9'h060))
      else $error("most negative trim not applied");
endmodule

// File: verif/mst_host_model.sv
// host model: writes and reads 16-bit registers over the serial port
// assumes the device samples din on sclk rise and shifts dout on sclk fall
`timescale 1ns/10ps
module mst_host_model #(
   parameter int HALF_CYC = 8 // sclk half period in clocks
) (
   input wire logic clock_i,
   input wire logic dout_i,
   input wire logic dout_oe_i,
   output logic cs_o,
   output logic sclk_o,
   output logic din_o,
   output logic rd_done_o,
   output logic [15:0] rd_data_o
);
   // idle state: clock stands still low outside frames
   initial
   begin
      cs_o = 1'b0;
      sclk_o = 1'b0;
      din_o = 1'b0;
      rd_done_o = 1'b0;
      rd_data_o = 16'h0000;
   end

   // one 24-bit frame, lsb first; read bits taken late in each high phase
   task automatic frame(input logic [5:0] addr, input logic rd, input logic [15:0] data);
      logic [23:0] bits;
      bits = {data, 1'b0, rd, addr};
      @(posedge clock_i);
      cs_o <= 1'b1;
      for (int i = 0; i < 24; i++)
      begin
         din_o <= bits[i];
         repeat (HALF_CYC) @(posedge clock_i);
         sclk_o <= 1'b1;
         repeat (HALF_CYC) @(posedge clock_i);
         // undriven read line must not pass for data
         if (i >= 7 && i < 23)
            rd_data_o[i - 7] <= dout_oe_i ? dout_i : 1'bx;
         sclk_o <= 1'b0;
      end
      repeat (HALF_CYC) @(posedge clock_i);
      cs_o <= 1'b0;
      // a dropped frame shows the inverse, never a held level
      din_o <= ~bits[23];
      repeat (HALF_CYC) @(posedge clock_i);
      rd_done_o <= rd;
      @(posedge clock_i);
      rd_done_o <= 1'b0;
   endtask
endmodule

// File: verif/tb_mst_microstep_timing_setup.sv
// self-checking bench for the frame timing and setup block
// assumes a short wait unit and a host model on the serial pins
`timescale 1ns/10ps
module tb_mst_microstep_timing_setup;
   localparam int UNIT = 4; // short wait unit keeps frames brief
   logic clock_i, rst_n_i, frame_sync_in_i;
   logic cs, sclk, din, dout, dout_oe, rd_done;
   logic [15:0] rd_data;
   logic [3:0] coil_pwm;
   logic [8:0] alpha_ph, beta_ph;
   logic fsw, aew, bew, arun, brun;
   logic [2:0] flags;
   logic [15:0] exp_q[$]; // expected read words, oldest first
   int miscompares = 0;
   int tests_run = 0;
   int seed = 43927;
   assign flags = {bew, aew, fsw};

   mst_microstep_timing_setup #(.UNIT_CYC(UNIT)) u_mst_microstep_timing_setup (
      .clock_i(clock_i), .rst_n_i(rst_n_i), .serial_cs_i(cs), .serial_clk_i(sclk),
      .serial_din_i(din), .serial_dout_o(dout), .serial_dout_oe_o(dout_oe),
      .frame_sync_in_i(frame_sync_in_i), .coil_pwm_o(coil_pwm),
      .alpha_phase_diff_o(alpha_ph), .beta_phase_diff_o(beta_ph),
      .frame_start_wait_o(fsw), .alpha_excite_wait_o(aew), .beta_excite_wait_o(bew),
      .alpha_run_o(arun), .beta_run_o(brun));

   mst_host_model u_mst_host_model (
      .clock_i(clock_i), .dout_i(dout), .dout_oe_i(dout_oe), .cs_o(cs),
      .sclk_o(sclk), .din_o(din), .rd_done_o(rd_done), .rd_data_o(rd_data));

   // free-running system clock
   initial
   begin
      clock_i = 1'b0;
      forever #5 clock_i = ~clock_i;
   end

   task automatic check(input logic [15:0] seen, input logic [15:0] want);
      tests_run++;
      if (seen !== want)
      begin
         miscompares++;
         $display("[FAIL] t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask

   task automatic close_out();
      if (miscompares == 0 && tests_run > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // read results are matched against the oldest note
   always @(posedge clock_i)
   begin
      if (rd_done === 1'b1 && exp_q.size() > 0)
         check(rd_data, exp_q.pop_front());
   end

   task automatic wr(input logic [5:0] a, input logic [15:0] d);
      u_mst_host_model.frame(a, 1'b0, d);
   endtask

   task automatic rd(input logic [5:0] a, input logic [15:0] want);
      exp_q.push_back(want);
      u_mst_host_model.frame(a, 1'b1, 16'h0000);
   endtask

   task automatic phases(input logic [8:0] a, input logic [8:0] b);
      check(16'(alpha_ph), 16'(a));
      check(16'(beta_ph), 16'(b));
   endtask

   // waits for a chosen wait flag to rise, then times its high span
   task automatic span(input int idx, output int lead, output int len);
      lead = 0;
      len = 0;
      while (flags[idx] !== 1'b1 && lead < 200)
      begin
         @(negedge clock_i);
         lead++;
      end
      while (flags[idx] === 1'b1 && len < 2000)
      begin
         @(negedge clock_i);
         len++;
      end
   endtask

   // one frame: start wait, then both excitation waits side by side
   task automatic run_frame(input int sw, input int aw, input int bw);
      int l0, n0, l1, n1, l2, n2;
      @(posedge clock_i);
      frame_sync_in_i <= 1'b1;
      repeat (2) @(posedge clock_i);
      frame_sync_in_i <= 1'b0;
      span(0, l0, n0);
      fork
         span(1, l1, n1);
         span(2, l2, n2);
      join
      check(16'(n0), 16'(sw * UNIT));
      check(16'(n1), 16'(aw * UNIT));
      check(16'(n2), 16'(bw * UNIT));
      if (aw != 0)
         check(16'(l1 <= 2), 16'h0001);
      repeat (4) @(posedge clock_i);
   endtask

   // counts high cycles of each coil over n cycles
   task automatic duty(input int n, input int a, input int b, input int c, input int d);
      int k[4];
      k = '{0, 0, 0, 0};
      repeat (n)
      begin
         @(negedge clock_i);
         for (int j = 0; j < 4; j++)
            k[j] += int'(coil_pwm[j] === 1'b1);
      end
      check(16'(k[0]), 16'(a));
      check(16'(k[1]), 16'(b));
      check(16'(k[2]), 16'(c));
      check(16'(k[3]), 16'(d));
   endtask

   // main sequence
   initial
   begin
      logic [15:0] r;
      rst_n_i = 1'b0;
      frame_sync_in_i = 1'b0;
      repeat (10) @(posedge clock_i);
      rst_n_i <= 1'b1;
      // reset contents and an unmapped place
      rd(6'h20, 16'h3C0A);
      rd(6'h22, 16'h0003);
      rd(6'h23, 16'h0000);
      rd(6'h27, 16'h0003);
      rd(6'h28, 16'h0000);
      rd(6'h3F, 16'h0000);
      // status after reset: idle phase, no wait busy
      rd(6'h2F, 16'h0008);
      // random peak and beta excitation words, all-ones sync word; reserved bits stored as zero
      r = 16'($random(seed));
      wr(6'h23, r);
      rd(6'h23, r);
      r = 16'($random(seed));
      wr(6'h27, r);
      rd(6'h27, r & 16'h3FFF);
      wr(6'h20, 16'hFFFF);
      rd(6'h20, 16'h7FFF);
      // first frame: div 1, res 0, trims +31 and -32
      wr(6'h20, 16'h0102);
      wr(6'h22, 16'h1F01);
      wr(6'h27, 16'h2003);
      wr(6'h23, 16'h0008);
      wr(6'h28, 16'hC804);
      phases(9'h080, 9'h080);
      check(16'({arun, brun}), 16'h0000);
      run_frame(2, 1, 3);
      phases(9'h09F, 9'h060);
      check(16'({arun, brun}), 16'h0003);
      duty(16, 16, 0, 8, 16);
      // divider zero acts as one, resolution one doubles the period
      wr(6'h20, 16'h2002);
      wr(6'h22, 16'h0001);
      phases(9'h09F, 9'h060);
      run_frame(2, 1, 3);
      phases(9'h080, 9'h060);
      duty(32, 32, 0, 16, 32);
      // zero beta wait keeps beta settings
      wr(6'h27, 16'h0000);
      wr(6'h22, 16'h0501);
      run_frame(2, 1, 0);
      phases(9'h085, 9'h060);
      // zero start wait blocks every update
      wr(6'h20, 16'h2000);
      wr(6'h22, 16'h0A01);
      run_frame(0, 0, 0);
      phases(9'h085, 9'h060);
      check(16'(exp_q.size()), 16'h0000);
      close_out();
   end

   // hang guard, well beyond the expected run
   initial
   begin
      #300000;
      miscompares++;
      close_out();
   end
endmodule
